// ==== include/sms_defs.svh ====
// Constants of the master serial interface: phase timing, bit counts, idle levels.
// Assumes a 25 MHz system clock; included by both design files.
`ifndef SMS_DEFS_SVH
`define SMS_DEFS_SVH

// Clock period in ns
`define SMS_CLK_NS        40
// Quarter of an I2C bit time in ns (about 100 kbit/s)
`define SMS_I2C_QTR_NS    2500
// Quarter bit in clk cycles, rounded down
`define SMS_I2C_QTR_CYC   (8'((`SMS_I2C_QTR_NS) / (`SMS_CLK_NS)))
// Quarter of an SPI bit in clk cycles
`define SMS_SPI_QTR_CYC   8'h02
// Index of the last bit of a byte cell
`define SMS_SPI_LAST_BIT  4'h7
`define SMS_I2C_LAST_BIT  4'h8
// All selects released
`define SMS_SEL_IDLE      3'h7
// Entries of the response buffer
`define SMS_BUF_DEPTH     2'h2

`endif

// ==== include/sms_pkg.sv ====
// Types of the master serial interface: modes, targets, states, carriers.
// Assumes sms_defs.svh sits in the include path.
package sms_pkg;

  typedef enum logic [1:0] {
    SMS_MODE_I2C  = 2'h0,
    SMS_MODE_SPI3 = 2'h1,
    SMS_MODE_SPI4 = 2'h2
  } sms_mode_e;

  typedef enum logic [1:0] {
    SMS_TGT_FLASH  = 2'h0,
    SMS_TGT_USER   = 2'h1,
    SMS_TGT_EEPROM = 2'h2,
    SMS_TGT_GPIO   = 2'h3
  } sms_tgt_e;

  typedef enum logic [4:0] {
    SMS_ST_IDLE  = 5'h01,
    SMS_ST_START = 5'h02,
    SMS_ST_BIT   = 5'h04,
    SMS_ST_PUSH  = 5'h08,
    SMS_ST_STOP  = 5'h10
  } sms_st_e;

  typedef struct packed {
    sms_mode_e  mode;
    sms_tgt_e   tgt;
    logic       rd;
    logic       last;
    logic [7:0] data;
  } sms_cmd_s;

  typedef struct packed {
    logic       from_slave;
    logic       ack_n;
    logic [7:0] data;
  } sms_rsp_s;

  typedef struct packed {
    sms_rsp_s [1:0] mem;
    logic           wp;
    logic           rp;
    logic [1:0]     cnt;
  } sms_fifo_s;

  typedef struct packed {
    sms_st_e    st;
    logic [1:0] ph;
    logic [7:0] cyc;
    logic [3:0] bits;
    logic [7:0] sh;
    logic       ack;
    sms_cmd_s   cmd;
    logic       frame_open;
    logic [2:0] sel_n;
    logic       sclk;
    logic       mosi;
    logic       mosi_oe;
    logic       scl_oe;
    logic       sda_oe;
    logic       miso_s1;
    logic       miso_s2;
    logic       sio_s1;
    logic       sio_s2;
    logic       sda_s1;
    logic       sda_s2;
    logic       tog_s1;
    logic       tog_s2;
    logic       tog_s3;
    logic       slv_pend;
    logic [7:0] slv_word;
    logic       ovr;
    logic       lrst;
  } sms_core_s;

  typedef struct packed {
    logic [7:0] sh;
    logic [7:0] word;
    logic       tog;
  } sms_link_s;

endpackage

// ==== logic/sms_fifo2.sv ====
// Two-entry response buffer with valid/ready on both sides.
// Assumes one clock, synchronous active-low reset and a freezing clock enable.
`timescale 1ns/1ps
`include "sms_defs.svh"

module sms_fifo2 (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              ce,
  input  wire logic              in_valid,
  output      logic              in_ready,
  input  wire sms_pkg::sms_rsp_s in_data,
  output      logic              out_valid,
  input  wire logic              out_ready,
  output      sms_pkg::sms_rsp_s out_data
);
  import sms_pkg::*;

  sms_fifo_s q;
  sms_fifo_s d;
  logic      push;
  logic      pop;

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes stall while frozen
  assign in_ready  = ce & (q.cnt != `SMS_BUF_DEPTH);
  assign out_valid = ce & (q.cnt != 2'h0);
  assign out_data  = q.mem[q.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp        = ~q.wp;
    end
    if (pop) begin
      d.rp = ~q.rp;
    end
    d.cnt = 2'(q.cnt + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

endmodule

// ==== logic/sms_top.sv ====
// Master serial interface: I2C / 3-wire / 4-wire SPI master plus SPI slave port.
// Assumes commands from on-chip logic on clk, pins from the board, host on slv_clk.
//
// Summary of operation
// - The master runs as a two-wire, three-wire or four-wire serial bus, chosen per frame.
// - I2C targets share the two-wire bus and are picked only by their address byte.
// - Extra SPI targets share clock and data and are selected by software-driven GPIO.
// - As an SPI master the block drives three dedicated select outputs, one per target.
// - Every select is active low, and an unused select is simply left open on the board.
// - An SPI slave port lets an external host use the serial port as its host interface.
// - The first select enables the serial flash holding patch code and management data.
// - Patch code and management data may instead arrive from the host over the slave port.
// - The second select serves a user peripheral such as an audio codec or sensor ADC.
// - The third select serves an EEPROM with per-unit data or general use.
`timescale 1ns/1ps
`include "sms_defs.svh"

module sms_top (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              ce,
  input  wire logic              cmd_valid,
  output      logic              cmd_ready,
  input  wire sms_pkg::sms_cmd_s cmd,
  output      logic              rsp_valid,
  input  wire logic              rsp_ready,
  output      sms_pkg::sms_rsp_s rsp,
  output      logic              flash_select_n,
  output      logic              user_select_n,
  output      logic              eeprom_select_n,
  output      logic              spi_sclk,
  output      logic              spi_mosi_o,
  output      logic              spi_mosi_oe,
  input  wire logic              spi_mosi_i,
  input  wire logic              spi_miso,
  output      logic              i2c_scl_o,
  output      logic              i2c_scl_oe,
  output      logic              i2c_sda_o,
  output      logic              i2c_sda_oe,
  input  wire logic              i2c_sda_i,
  input  wire logic              slv_clk,
  input  wire logic              slv_sel_n,
  input  wire logic              slv_mosi,
  output      logic              slv_miso_o,
  output      logic              slv_miso_oe,
  output      logic              slv_overrun
);
  import sms_pkg::*;

  localparam sms_core_s CORE_RST = '{st: SMS_ST_IDLE, sel_n: `SMS_SEL_IDLE, lrst: 1'b1,
                                     default: '0};

  sms_core_s q;
  sms_core_s d;
  sms_link_s lq;
  logic [2:0] slv_cnt_q;
  logic       tick;
  logic       slv_evt;
  logic       rx_bit;
  logic       i2c_q;
  logic       i2c_d;
  logic       i2c_tx;
  logic       in_bit;
  logic       last_bit;
  logic       buf_valid;
  logic       buf_ready;
  logic       push_ok;
  sms_rsp_s   buf_data;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: SPI slave receiver on the host clock
  always_ff @(posedge slv_clk or posedge slv_sel_n) begin
    if (slv_sel_n) begin
      slv_cnt_q <= 3'h0;
    end else begin
      slv_cnt_q <= 3'(slv_cnt_q + 3'h1);
    end
  end

  always_ff @(posedge slv_clk or posedge q.lrst) begin
    if (q.lrst) begin
      lq <= '0;
    end else begin
      lq.sh <= {lq.sh[6:0], slv_mosi};
      if (slv_cnt_q == 3'h7) begin
        lq.word <= {lq.sh[6:0], slv_mosi};
        lq.tog  <= ~lq.tog;
      end
    end
  end

  // Echo of the previous host byte, MSB first
  assign slv_miso_o  = lq.word[~slv_cnt_q];
  assign slv_miso_oe = ~slv_sel_n;

  ////////////////////////////////////////////////////////////////////////////
  // Response buffer: slave words first, master bytes wait
  assign buf_valid = q.slv_pend | (q.st == SMS_ST_PUSH);
  assign buf_data  = q.slv_pend ? '{from_slave: 1'b1, ack_n: 1'b0, data: q.slv_word}
                                : '{from_slave: 1'b0, ack_n: q.ack, data: q.sh};
  assign push_ok   = buf_valid & buf_ready;

  sms_fifo2 u_buf (
    .clk       (clk),
    .rst_b     (rst_b),
    .ce        (ce),
    .in_valid  (buf_valid),
    .in_ready  (buf_ready),
    .in_data   (buf_data),
    .out_valid (rsp_valid),
    .out_ready (rsp_ready),
    .out_data  (rsp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Master engine
  assign i2c_q     = (q.cmd.mode == SMS_MODE_I2C);
  assign cmd_ready = ce & (q.st == SMS_ST_IDLE);
  assign tick      = (q.cyc == 8'((i2c_q ? `SMS_I2C_QTR_CYC : `SMS_SPI_QTR_CYC) - 8'h01));
  assign slv_evt   = q.tog_s2 ^ q.tog_s3;
  assign last_bit  = (q.bits == (i2c_q ? `SMS_I2C_LAST_BIT : `SMS_SPI_LAST_BIT));

  always_comb begin
    unique case (q.cmd.mode)
      SMS_MODE_I2C:  rx_bit = q.sda_s2;
      SMS_MODE_SPI3: rx_bit = q.sio_s2;
      default:       rx_bit = q.miso_s2;
    endcase
  end

  always_comb begin
    d = q;
    d.lrst    = 1'b0;
    d.miso_s1 = spi_miso;
    d.miso_s2 = q.miso_s1;
    d.sio_s1  = spi_mosi_i;
    d.sio_s2  = q.sio_s1;
    d.sda_s1  = i2c_sda_i;
    d.sda_s2  = q.sda_s1;
    d.tog_s1  = lq.tog;
    d.tog_s2  = q.tog_s1;
    d.tog_s3  = q.tog_s2;
    // Host words, set wins over the push clear
    if (push_ok && q.slv_pend) begin
      d.slv_pend = 1'b0;
    end
    if (slv_evt) begin
      if (q.slv_pend && !push_ok) begin
        d.ovr = 1'b1;
      end
      d.slv_pend = 1'b1;
      d.slv_word = lq.word;
    end
    if (q.st inside {SMS_ST_START, SMS_ST_BIT, SMS_ST_STOP}) begin
      d.cyc = tick ? 8'h00 : 8'(q.cyc + 8'h01);
      d.ph  = tick ? 2'(q.ph + 2'h1) : q.ph;
    end
    unique case (q.st)
      SMS_ST_IDLE: begin
        if (cmd_valid && cmd_ready) begin
          d.cmd.rd   = cmd.rd;
          d.cmd.last = cmd.last;
          d.cmd.data = cmd.data;
          d.sh       = cmd.data;
          d.ack      = 1'b0;
          d.cyc      = 8'h00;
          d.ph       = 2'h0;
          d.bits     = 4'h0;
          d.st       = SMS_ST_BIT;
          if (!q.frame_open) begin
            d.cmd.mode = cmd.mode;
            d.cmd.tgt  = cmd.tgt;
            if (cmd.mode == SMS_MODE_I2C) begin
              d.st = SMS_ST_START;
            end else if (cmd.tgt != SMS_TGT_GPIO) begin
              d.sel_n[cmd.tgt] = 1'b0;
            end
          end
          d.frame_open = 1'b1;
        end
      end
      SMS_ST_START: begin
        if (tick && q.ph == 2'h3) begin
          d.st = SMS_ST_BIT;
        end
      end
      SMS_ST_BIT: begin
        if (tick && q.ph == 2'h3) begin
          if (q.bits == 4'h8) begin
            d.ack = rx_bit;
          end else begin
            d.sh = {q.sh[6:0], rx_bit};
          end
          d.bits = 4'(q.bits + 4'h1);
          if (last_bit) begin
            d.st = SMS_ST_PUSH;
          end
        end
      end
      SMS_ST_PUSH: begin
        if (push_ok && !q.slv_pend) begin
          d.st = SMS_ST_IDLE;
          if (q.cmd.last) begin
            if (i2c_q) begin
              d.st = SMS_ST_STOP;
            end else begin
              d.sel_n      = `SMS_SEL_IDLE;
              d.frame_open = 1'b0;
            end
          end
        end
      end
      SMS_ST_STOP: begin
        if (tick && q.ph == 2'h3) begin
          d.frame_open = 1'b0;
          d.st         = SMS_ST_IDLE;
        end
      end
    endcase
    // Pin levels registered from the next state
    i2c_d     = (d.cmd.mode == SMS_MODE_I2C) & d.frame_open;
    in_bit    = (d.st == SMS_ST_BIT);
    i2c_tx    = (d.bits == 4'h8) ? (d.cmd.rd ? d.cmd.last : 1'b1) : (d.cmd.rd | d.sh[7]);
    d.sclk    = in_bit & d.ph[1] & ~i2c_d;
    d.mosi    = d.sh[7];
    d.mosi_oe = in_bit & ~i2c_d & d.frame_open &
                ~((d.cmd.mode == SMS_MODE_SPI3) & d.cmd.rd);
    d.scl_oe  = i2c_d & ((in_bit & ~d.ph[1]) | (d.st == SMS_ST_START & d.ph[1]) |
                         (d.st == SMS_ST_STOP & d.ph == 2'h0) | (d.st == SMS_ST_PUSH) |
                         (d.st == SMS_ST_IDLE));
    // Outside start and stop, data only moves while the clock line is low
    if (i2c_d && ((in_bit && d.ph == 2'h0) || d.st == SMS_ST_PUSH || d.st == SMS_ST_IDLE))
    begin
      d.sda_oe = q.sda_oe;
    end else begin
      d.sda_oe = i2c_d & ((in_bit & ~i2c_tx) | (d.st == SMS_ST_START & d.ph != 2'h0) |
                          (d.st == SMS_ST_STOP & ~d.ph[1]));
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= CORE_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins
  assign flash_select_n  = q.sel_n[0];
  assign user_select_n   = q.sel_n[1];
  assign eeprom_select_n = q.sel_n[2];
  assign spi_sclk        = q.sclk;
  assign spi_mosi_o      = q.mosi;
  assign spi_mosi_oe     = q.mosi_oe;
  assign i2c_scl_o       = 1'b0;
  assign i2c_scl_oe      = q.scl_oe;
  assign i2c_sda_o       = 1'b0;
  assign i2c_sda_oe      = q.sda_oe;
  assign slv_overrun     = q.ovr;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_sel_one_low: assert property ($countones(~q.sel_n) <= 1)
    else $error("more than one select low");
  a_sel_reset_idle: assert property (!$past(rst_b) |-> q.sel_n == `SMS_SEL_IDLE)
    else $error("select not high after reset");
  a_flash_sel_map: assert property ((q.st == SMS_ST_BIT && !i2c_q &&
      q.cmd.tgt == SMS_TGT_FLASH) |-> q.sel_n == 3'h6)
    else $error("flash transfer without flash select");
  a_user_sel_map: assert property ((q.st == SMS_ST_BIT && !i2c_q &&
      q.cmd.tgt == SMS_TGT_USER) |-> q.sel_n == 3'h5)
    else $error("user transfer without user select");
  a_eeprom_sel_map: assert property ((q.st == SMS_ST_BIT && !i2c_q &&
      q.cmd.tgt == SMS_TGT_EEPROM) |-> q.sel_n == 3'h3)
    else $error("eeprom transfer without eeprom select");
  a_gpio_no_sel: assert property ((q.frame_open && (i2c_q ||
      q.cmd.tgt == SMS_TGT_GPIO)) |-> q.sel_n == `SMS_SEL_IDLE)
    else $error("dedicated select on gpio or i2c frame");
  a_sel_whole_frame: assert property ((q.st == SMS_ST_IDLE && q.frame_open && !i2c_q &&
      q.cmd.tgt != SMS_TGT_GPIO) |-> q.sel_n != `SMS_SEL_IDLE)
    else $error("select released inside a frame");
  a_sel_release_end: assert property ((q.st == SMS_ST_PUSH && push_ok && !q.slv_pend &&
      q.cmd.last && !i2c_q) |=> q.sel_n == `SMS_SEL_IDLE && q.st == SMS_ST_IDLE)
    else $error("select not released after last byte");
  a_mode_pin_use: assert property ((q.st == SMS_ST_BIT && q.ph == 2'h2 && !$past(q.st == SMS_ST_IDLE))
      |-> (i2c_q ? (!q.sclk && !q.mosi_oe) : (q.sclk && !q.scl_oe)))
    else $error("wrong pins active for bus mode");
  a_i2c_start_cond: assert property ((q.st == SMS_ST_START && q.ph == 2'h1 &&
      q.cyc == 8'h00) |-> (q.sda_oe && !$past(q.sda_oe) && !q.scl_oe))
    else $error("i2c start without falling data line");
  a_host_word_kept: assert property ((slv_evt |=> q.slv_pend) and
      ((q.slv_pend && buf_ready) |-> push_ok))
    else $error("host word not pushed");

  c_flash_frame: cover property (q.st == SMS_ST_PUSH && !flash_select_n && q.cmd.last);
  c_i2c_stop: cover property (q.st == SMS_ST_STOP && q.ph == 2'h3);
  c_host_word: cover property (push_ok && q.slv_pend);
  c_spi3_read: cover property (q.st == SMS_ST_BIT && q.cmd.mode == SMS_MODE_SPI3 && q.cmd.rd);

endmodule

// ==== bench/sms_peer.sv ====
// Far-side model: SPI target behind the dedicated selects, I2C target at one address.
// Assumes pull-ups outside the device; this model resolves the sio and sda wires.
`timescale 1ns/1ps

module sms_peer #(
  parameter logic [7:0] SPI_REPLY = 8'hA5,
  parameter logic [6:0] I2C_ADDR  = 7'h2C
) (
  input  wire logic       spi_sclk,
  input  wire logic [2:0] sel_n,
  input  wire logic       spi_mosi_o,
  input  wire logic       spi_mosi_oe,
  output      logic       spi_mosi_i,
  output      logic       spi_miso,
  output      logic [7:0] spi_rx,
  input  wire logic       i2c_scl_oe,
  input  wire logic       i2c_sda_oe,
  output      logic       i2c_sda_i
);
  wire logic  sel;
  wire logic  scl;
  wire logic  sda;
  logic [2:0] idx;
  logic       out_q = 1'h0;
  logic       ack_n = 1'h1;
  int         cnt   = 100;
  logic [7:0] i2c_sh;

  ////////////////////////////////////////////////////////////////////////////////
  // SPI target, mode 0, MSB first
  assign sel        = ~&sel_n;
  assign spi_miso   = out_q;
  assign spi_mosi_i = spi_mosi_oe ? spi_mosi_o : out_q;
  always @(posedge sel) begin
    out_q = SPI_REPLY[7];
    idx   = 3'h6;
  end
  always @(negedge sel) out_q = ~out_q;
  always @(negedge spi_sclk) if (sel) begin
    out_q = SPI_REPLY[idx];
    idx   = idx - 3'h1;
  end
  always @(posedge spi_sclk) if (sel) spi_rx = {spi_rx[6:0], spi_mosi_i};

  ////////////////////////////////////////////////////////////////////////////////
  // I2C target with pull-ups, acks its own address only
  assign scl       = ~(i2c_scl_oe === 1'h1);
  assign sda       = ~((i2c_sda_oe === 1'h1) | ~ack_n);
  assign i2c_sda_i = sda;
  always @(negedge sda) if (scl) cnt = -1;
  always @(posedge scl) i2c_sh = {i2c_sh[6:0], sda};
  always @(negedge scl) begin
    cnt   = cnt + 1;
    ack_n = ~(cnt == 8 && i2c_sh[7:1] == I2C_ADDR);
  end
endmodule

// ==== bench/serial_master_si_spi_test.sv ====
// Self-checking bench of the master serial interface.
// Assumes the far-side model in sms_peer and a host link driven here at 48 ns.
`timescale 1ns/1ps

module serial_master_si_spi_test;
  import sms_pkg::*;
  localparam logic [7:0] REPLY = 8'hA5;
  localparam logic [6:0] ADDR  = 7'h2C;
  logic       clk, rst_b, ce, cmd_valid, rsp_ready, slv_clk, slv_sel_n, slv_mosi;
  wire logic  cmd_ready, rsp_valid, sclk, mosi_o, mosi_oe, mosi_i, miso;
  wire logic  scl_oe, sda_oe, sda_i, overrun, smiso_oe;
  logic       last_cmd = 1'h1;
  wire logic [2:0] sel_n;
  wire logic [7:0] rx;
  sms_cmd_s   cmd;
  sms_rsp_s   rsp;
  int         err_count, compares;
  int         cycles = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Design and far side
  sms_top u_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp(rsp), .flash_select_n(sel_n[0]), .user_select_n(sel_n[1]),
    .eeprom_select_n(sel_n[2]), .spi_sclk(sclk), .spi_mosi_o(mosi_o),
    .spi_mosi_oe(mosi_oe), .spi_mosi_i(mosi_i), .spi_miso(miso), .i2c_scl_o(),
    .i2c_scl_oe(scl_oe), .i2c_sda_o(), .i2c_sda_oe(sda_oe), .i2c_sda_i(sda_i),
    .slv_clk(slv_clk), .slv_sel_n(slv_sel_n), .slv_mosi(slv_mosi), .slv_miso_o(),
    .slv_miso_oe(smiso_oe), .slv_overrun(overrun));
  sms_peer #(.SPI_REPLY(REPLY), .I2C_ADDR(ADDR)) u_peer (.spi_sclk(sclk),
    .sel_n(sel_n), .spi_mosi_o(mosi_o), .spi_mosi_oe(mosi_oe), .spi_mosi_i(mosi_i),
    .spi_miso(miso), .spi_rx(rx), .i2c_scl_oe(scl_oe), .i2c_sda_oe(sda_oe),
    .i2c_sda_i(sda_i));

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic test_done();
    if (err_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic send(input sms_mode_e m, input sms_tgt_e t, input logic rd,
                      input logic [7:0] d);
    for (int n = 0; n < 9000 && cmd_ready !== 1'h1; n++) @(negedge clk);
    cmd       = '{m, t, rd, last_cmd, d};
    cmd_valid = 1'h1;
    @(negedge clk);
    cmd_valid = 1'h0;
  endtask

  task automatic pop(input string what, input sms_rsp_s exp);
    for (int n = 0; n < 9000 && rsp_valid !== 1'h1; n++) @(negedge clk);
    chk(what, 10'(exp), 10'(rsp));
    rsp_ready = 1'h1;
    @(negedge clk);
    rsp_ready = 1'h0;
  endtask

  task automatic host_byte(input logic [7:0] b);
    #7 slv_sel_n = 1'h0;
    #1 chk("host miso enable", 10'h1, 10'(smiso_oe));
    for (int i = 7; i >= 0; i--) begin
      slv_mosi = b[i];
      #24 slv_clk = 1'h1;
      #24 slv_clk = 1'h0;
    end
    #24 slv_sel_n = 1'h1;
    slv_mosi = ~slv_mosi;
    repeat (8) @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    chk("selects in reset", 10'h7, 10'(sel_n));
    chk("idle pins", 10'h0, 10'({sclk, mosi_oe, scl_oe, sda_oe, rsp_valid, overrun}));
  endtask

  task automatic t_spi4();
    logic [2:0] exp;
    for (int t = 0; t < 4; t++) begin
      exp = (t < 3) ? ~(3'h1 << t) : 3'h7;
      send(SMS_MODE_SPI4, sms_tgt_e'(t), 1'h0, 8'h3C ^ 8'(t));
      repeat (20) @(negedge clk);
      chk("select mid frame", 10'(exp), 10'(sel_n));
      if (t < 3) begin
        pop("spi4 reply", '{1'h0, 1'h0, REPLY});
        chk("target received", 10'(8'h3C ^ 8'(t)), 10'(rx));
        chk("selects after", 10'h7, 10'(sel_n));
      end else begin
        rsp_ready = 1'h1;
        repeat (70) @(negedge clk);
        rsp_ready = 1'h0;
        chk("buffer empty", 10'h0, 10'(rsp_valid));
      end
    end
  endtask

  task automatic t_spi3();
    last_cmd = 1'h0;
    send(SMS_MODE_SPI3, SMS_TGT_FLASH, 1'h1, 8'h00);
    pop("spi3 first reply", '{1'h0, 1'h0, REPLY});
    last_cmd = 1'h1;
    repeat (4) @(negedge clk);
    chk("select held between bytes", 10'h6, 10'(sel_n));
    send(SMS_MODE_SPI3, SMS_TGT_FLASH, 1'h1, 8'h00);
    repeat (20) @(negedge clk);
    chk("sio released", 10'h0, 10'(mosi_oe));
    pop("spi3 reply", '{1'h0, 1'h0, REPLY});
  endtask

  task automatic t_i2c();
    logic [7:0] b;
    for (int k = 0; k < 2; k++) begin
      b = {ADDR ^ 7'(k), 1'h0};
      send(SMS_MODE_I2C, SMS_TGT_EEPROM, 1'h0, b);
      repeat (100) @(negedge clk);
      chk("no select in i2c", 10'h7, 10'(sel_n));
      pop("i2c address ack", '{1'h0, 1'(k), b});
    end
  endtask

  task automatic t_host();
    host_byte(8'h5A);
    pop("host byte", '{1'h1, 1'h0, 8'h5A});
  endtask

  task automatic t_buffer();
    host_byte(8'h11);
    host_byte(8'h22);
    host_byte(8'h33);
    host_byte(8'h44);
    chk("overrun", 10'h1, 10'(overrun));
    send(SMS_MODE_SPI4, SMS_TGT_USER, 1'h0, 8'h77);
    repeat (100) @(negedge clk);
    chk("engine held", 10'h0, 10'(cmd_ready));
    chk("select held", 10'h5, 10'(sel_n));
    pop("host first", '{1'h1, 1'h0, 8'h11});
    pop("host second", '{1'h1, 1'h0, 8'h22});
    pop("host replaced", '{1'h1, 1'h0, 8'h44});
    pop("master after", '{1'h0, 1'h0, REPLY});
    repeat (4) @(negedge clk);
    chk("drained", 10'h0, 10'(rsp_valid));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Monitor, timeout and main sequence
  always @(negedge clk) if (rst_b === 1'h1 && $countones(~sel_n) > 1) begin
    chk("single select", 10'h1, 10'h0);
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end

  initial begin
    err_count = 0;
    compares  = 0;
    rst_b     = 1'h0;
    ce        = 1'h1;
    cmd_valid = 1'h0;
    cmd       = '0;
    rsp_ready = 1'h0;
    slv_clk   = 1'h0;
    slv_sel_n = 1'h1;
    slv_mosi  = 1'h0;
    repeat (20) @(negedge clk);
    t_reset();
    rst_b = 1'h1;
    repeat (2) @(negedge clk);
    t_spi4();
    t_spi3();
    t_i2c();
    t_host();
    t_buffer();
    test_done();
  end
endmodule
